// *** core/ssp_pkg.sv ***
// Register map, field positions and state type of the serial port status block
package ssp_pkg;

  localparam int          SSP_ADDR_W      = 12;
  localparam int          SSP_DATA_W      = 32;
  localparam int          SSP_LEVEL_W     = 4;
  localparam int          SSP_SER_W       = 16;
  localparam int          SSP_NUM_IRQ     = 4;

  // Register byte offsets
  localparam logic [11:0] SSP_OFS_DATA    = 12'h008;
  localparam logic [11:0] SSP_OFS_STATUS  = 12'h00c;
  localparam logic [11:0] SSP_OFS_PRESC   = 12'h010;
  localparam logic [11:0] SSP_OFS_MASK    = 12'h014;
  localparam logic [11:0] SSP_OFS_RAW     = 12'h018;
  localparam logic [11:0] SSP_OFS_MIS     = 12'h01c;
  localparam logic [11:0] SSP_OFS_ICLR    = 12'h020;
  localparam logic [11:0] SSP_OFS_ID4     = 12'hfd0;
  localparam logic [11:0] SSP_OFS_ID5     = 12'hfd4;
  localparam logic [11:0] SSP_OFS_ID6     = 12'hfd8;

  // Status bit positions
  localparam int          SSP_BIT_BUSY    = 4;
  localparam int          SSP_BIT_RXFULL  = 3;
  localparam int          SSP_BIT_RXAVAIL = 2;
  localparam int          SSP_BIT_TXROOM  = 1;
  localparam int          SSP_BIT_TXEMPTY = 0;

  // Interrupt bit positions, shared by mask, raw, masked and clear
  localparam int          SSP_IRQ_TX      = 3;
  localparam int          SSP_IRQ_RX      = 2;
  localparam int          SSP_IRQ_RT      = 1;
  localparam int          SSP_IRQ_ROR     = 0;

  // FIFO geometry
  localparam logic [3:0]  SSP_FIFO_DEPTH  = 4'h8;
  localparam logic [3:0]  SSP_FIFO_HALF   = 4'h4;
  localparam logic [3:0]  SSP_LEVEL_EMPTY = 4'h0;

  // Prescaler
  localparam logic [7:0]  SSP_PRESC_RESET = 8'h00;
  localparam logic [7:0]  SSP_PRESC_MIN   = 8'h02;
  localparam logic [7:0]  SSP_PRESC_LSB0  = 8'hfe;
  localparam logic [7:0]  SSP_CNT_ONE     = 8'h01;

  // Identification bytes: values are arbitrary
  localparam logic [7:0]  SSP_ID_FOUR     = 8'h5a;
  localparam logic [7:0]  SSP_ID_FIVE     = 8'h3c;
  localparam logic [7:0]  SSP_ID_SIX      = 8'h71;

  // Bus responses
  localparam logic [1:0]  SSP_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SSP_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic                   awHeld;
    logic [SSP_ADDR_W-1:0]  awAddr;
    logic                   wHeld;
    logic [SSP_DATA_W-1:0]  wData;
    logic [3:0]             wStrb;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [SSP_DATA_W-1:0]  rdata;
    logic [7:0]             prescale;
    logic [SSP_NUM_IRQ-1:0] mask;
    logic                   rtRaw;
    logic                   rorRaw;
    logic [7:0]             preCnt;
    logic                   preTick;
    logic                   rxPop;
    logic                   txPush;
    logic [SSP_SER_W-1:0]   txData;
    logic                   irq;
  } ssp_state_t;

  localparam ssp_state_t SSP_STATE_RESET = '0;

endpackage

// *** core/ssp_status_irq.sv ***
// Status, prescaler, interrupt and identification registers of the serial port
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps

// Function
// - Busy bit 4 set while a frame moves or transmit FIFO holds data.
// - Status bit 3 reads 1 when receive FIFO full, else 0.
// - Status bit 2 reads 1 when receive FIFO holds an entry.
// - Status bit 1 reads 0 only when transmit FIFO full; resets to 1.
// - Status bit 0 reads 1 when transmit FIFO empty; resets to 1.
// - System clock divided by 8-bit prescale divisor in bits 7:0.
// - Divisor bit 0 hard-wired to zero; odd writes read back even.
// - Interrupt mask is read/write, cleared at reset, one enables a source.
// - Mask bits: transmit level 3, receive level 2, time-out 1, overrun 0.
// - Raw interrupt status is read-only, unmasked, writes ignored.
// - Raw transmit bit 3 high while transmit occupancy at or below half.
// - Raw receive bit 2 high while receive occupancy at or above half.
// - Raw time-out bit 1 set on receive time-out, held until cleared.
// - Raw overrun bit 0 set on receive overflow, held until cleared.
// - Masked status equals raw AND mask, read-only, writes ignored.
// - Writing clear register: bit 1 clears time-out, bit 0 clears overrun.
// - Identification registers return fixed bytes in bits 7:0, upper bits zero.
// - Data register read pops receive FIFO, write pushes transmit FIFO.
module ssp_status_irq
  import ssp_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   clkEn,
  // AXI4-Lite slave
  input  wire logic [SSP_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [SSP_DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [SSP_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [SSP_DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // FIFO and shifter side
  input  wire logic [SSP_LEVEL_W-1:0] txLevel,
  input  wire logic [SSP_LEVEL_W-1:0] rxLevel,
  input  wire logic                   frameActive,
  input  wire logic [SSP_SER_W-1:0]   rxData,
  input  wire logic                   rxTimeoutEvt,
  input  wire logic                   rxOverrunEvt,
  output logic                        rxPop,
  output logic                        txPush,
  output logic [SSP_SER_W-1:0]        txData,
  output logic                        portClockTick,
  output logic                        intrReq
);

  ssp_state_t st_ff;
  ssp_state_t nxt_st;

  // Live raw interrupt vector
  function automatic logic [SSP_NUM_IRQ-1:0] rawFn(
    input logic [SSP_LEVEL_W-1:0] txLv,
    input logic [SSP_LEVEL_W-1:0] rxLv,
    input logic                   rt,
    input logic                   ror
  );
    logic [SSP_NUM_IRQ-1:0] v;
    v              = '0;
    v[SSP_IRQ_TX]  = (txLv <= SSP_FIFO_HALF);
    v[SSP_IRQ_RX]  = (rxLv >= SSP_FIFO_HALF);
    v[SSP_IRQ_RT]  = rt;
    v[SSP_IRQ_ROR] = ror;
    return v;
  endfunction

  // Live port status word
  function automatic logic [SSP_DATA_W-1:0] statusFn(
    input logic [SSP_LEVEL_W-1:0] txLv,
    input logic [SSP_LEVEL_W-1:0] rxLv,
    input logic                   active
  );
    logic [SSP_DATA_W-1:0] v;
    v               = '0;
    v[SSP_BIT_BUSY]    = active || (txLv != SSP_LEVEL_EMPTY);
    v[SSP_BIT_RXFULL]  = (rxLv == SSP_FIFO_DEPTH);
    v[SSP_BIT_RXAVAIL] = (rxLv != SSP_LEVEL_EMPTY);
    v[SSP_BIT_TXROOM]  = (txLv != SSP_FIFO_DEPTH);
    v[SSP_BIT_TXEMPTY] = (txLv == SSP_LEVEL_EMPTY);
    return v;
  endfunction

  // Word-aligned offset compare, low two address bits ignored
  function automatic logic hitFn(
    input logic [SSP_ADDR_W-1:0] addr,
    input logic [SSP_ADDR_W-1:0] ofs
  );
    return addr[SSP_ADDR_W-1:2] == ofs[SSP_ADDR_W-1:2];
  endfunction

  logic [SSP_NUM_IRQ-1:0] rawVec;
  logic [SSP_NUM_IRQ-1:0] misVec;
  logic                   doWrite;
  logic                   lane0;
  logic                   clrRt;
  logic                   clrRor;
  logic                   rdHit;
  logic [SSP_DATA_W-1:0]  rdWord;

  always_comb begin
    nxt_st  = st_ff;
    rawVec  = rawFn(txLevel, rxLevel, st_ff.rtRaw, st_ff.rorRaw);
    misVec  = rawVec & st_ff.mask;
    doWrite = 1'b0;
    lane0   = 1'b0;
    clrRt   = 1'b0;
    clrRor  = 1'b0;
    rdHit   = 1'b1;
    rdWord  = '0;

    // Strobes last one cycle
    nxt_st.rxPop   = 1'b0;
    nxt_st.txPush  = 1'b0;
    nxt_st.preTick = 1'b0;

    // Write address and data captured in either order
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.awHeld = 1'b1;
      nxt_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.wHeld = 1'b1;
      nxt_st.wData = s_axi_wdata;
      nxt_st.wStrb = s_axi_wstrb;
    end

    // Write response
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // Commit a write once both halves are held and no response pending
    if (st_ff.awHeld && st_ff.wHeld && !st_ff.bvalid) begin
      doWrite       = 1'b1;
      lane0         = st_ff.wStrb[0];
      nxt_st.awHeld = 1'b0;
      nxt_st.wHeld  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = SSP_RESP_OKAY;
      if (hitFn(st_ff.awAddr, SSP_OFS_DATA)) begin
        if (lane0) begin
          nxt_st.txPush = 1'b1;
          nxt_st.txData = st_ff.wData[SSP_SER_W-1:0];
        end
      end else if (hitFn(st_ff.awAddr, SSP_OFS_PRESC)) begin
        if (lane0) begin
          nxt_st.prescale = st_ff.wData[7:0] & SSP_PRESC_LSB0;
        end
      end else if (hitFn(st_ff.awAddr, SSP_OFS_MASK)) begin
        if (lane0) begin
          nxt_st.mask = st_ff.wData[SSP_NUM_IRQ-1:0];
        end
      end else if (hitFn(st_ff.awAddr, SSP_OFS_ICLR)) begin
        clrRt  = lane0 && st_ff.wData[SSP_IRQ_RT];
        clrRor = lane0 && st_ff.wData[SSP_IRQ_ROR];
      end else if (hitFn(st_ff.awAddr, SSP_OFS_STATUS) ||
                   hitFn(st_ff.awAddr, SSP_OFS_RAW) ||
                   hitFn(st_ff.awAddr, SSP_OFS_MIS) ||
                   hitFn(st_ff.awAddr, SSP_OFS_ID4) ||
                   hitFn(st_ff.awAddr, SSP_OFS_ID5) ||
                   hitFn(st_ff.awAddr, SSP_OFS_ID6)) begin
        // Read-only: write accepted and dropped
        nxt_st.bresp = SSP_RESP_OKAY;
      end else begin
        nxt_st.bresp = SSP_RESP_SLVERR;
      end
    end

    // Sticky sources: a new event beats a simultaneous clear
    if (clrRt) begin
      nxt_st.rtRaw = 1'b0;
    end
    if (rxTimeoutEvt) begin
      nxt_st.rtRaw = 1'b1;
    end
    if (clrRor) begin
      nxt_st.rorRaw = 1'b0;
    end
    if (rxOverrunEvt) begin
      nxt_st.rorRaw = 1'b1;
    end

    // Ready only while nothing of that kind is waiting
    nxt_st.awready = !nxt_st.awHeld && !nxt_st.bvalid;
    nxt_st.wready  = !nxt_st.wHeld && !nxt_st.bvalid;

    // Read channel
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arready) begin
      if (hitFn(s_axi_araddr, SSP_OFS_DATA)) begin
        rdWord       = {{(SSP_DATA_W-SSP_SER_W){1'b0}}, rxData};
        nxt_st.rxPop = 1'b1;
      end else if (hitFn(s_axi_araddr, SSP_OFS_STATUS)) begin
        rdWord = statusFn(txLevel, rxLevel, frameActive);
      end else if (hitFn(s_axi_araddr, SSP_OFS_PRESC)) begin
        rdWord = {{(SSP_DATA_W-8){1'b0}}, st_ff.prescale};
      end else if (hitFn(s_axi_araddr, SSP_OFS_MASK)) begin
        rdWord = {{(SSP_DATA_W-SSP_NUM_IRQ){1'b0}}, st_ff.mask};
      end else if (hitFn(s_axi_araddr, SSP_OFS_RAW)) begin
        rdWord = {{(SSP_DATA_W-SSP_NUM_IRQ){1'b0}}, rawVec};
      end else if (hitFn(s_axi_araddr, SSP_OFS_MIS)) begin
        rdWord = {{(SSP_DATA_W-SSP_NUM_IRQ){1'b0}}, misVec};
      end else if (hitFn(s_axi_araddr, SSP_OFS_ICLR)) begin
        // Write-only, reads as zero
        rdWord = '0;
      end else if (hitFn(s_axi_araddr, SSP_OFS_ID4)) begin
        rdWord = {{(SSP_DATA_W-8){1'b0}}, SSP_ID_FOUR};
      end else if (hitFn(s_axi_araddr, SSP_OFS_ID5)) begin
        rdWord = {{(SSP_DATA_W-8){1'b0}}, SSP_ID_FIVE};
      end else if (hitFn(s_axi_araddr, SSP_OFS_ID6)) begin
        rdWord = {{(SSP_DATA_W-8){1'b0}}, SSP_ID_SIX};
      end else begin
        rdHit = 1'b0;
      end
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rdWord;
      nxt_st.rresp  = rdHit ? SSP_RESP_OKAY : SSP_RESP_SLVERR;
    end
    nxt_st.arready = !nxt_st.rvalid;

    // Prescaler; divisors below two are illegal and stop the tick
    if (st_ff.prescale < SSP_PRESC_MIN) begin
      nxt_st.preCnt = '0;
    end else if (st_ff.preCnt + SSP_CNT_ONE >= st_ff.prescale) begin
      nxt_st.preCnt  = '0;
      nxt_st.preTick = 1'b1;
    end else begin
      nxt_st.preCnt = st_ff.preCnt + SSP_CNT_ONE;
    end

    // Level sources track the FIFOs live, only sticky ones need clearing
    nxt_st.irq = |(rawFn(txLevel, rxLevel, nxt_st.rtRaw, nxt_st.rorRaw)
                   & nxt_st.mask);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= SSP_STATE_RESET;
    end else if (clkEn) begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready  = st_ff.wready;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rresp   = st_ff.rresp;
  assign s_axi_rdata   = st_ff.rdata;
  assign rxPop         = st_ff.rxPop;
  assign txPush        = st_ff.txPush;
  assign txData        = st_ff.txData;
  assign portClockTick = st_ff.preTick;
  assign intrReq       = st_ff.irq;

endmodule // ssp_status_irq

// *** dv/ssp_status_irq_checker.sv ***
// Port-level assertions for the serial port status block
`timescale 1ns/100ps
module ssp_status_irq_checker
  import ssp_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic [SSP_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  input  wire logic                  s_axi_arready,
  input  wire logic                  s_axi_rvalid,
  input  wire logic [SSP_DATA_W-1:0] s_axi_rdata,
  input  wire logic                  s_axi_awvalid,
  input  wire logic                  s_axi_awready,
  input  wire logic                  s_axi_wvalid,
  input  wire logic                  s_axi_wready,
  input  wire logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic                  rxPop,
  input  wire logic                  txPush,
  input  wire logic                  portClockTick,
  input  wire logic                  intrReq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_pop_on_read: assert property (rxPop == ($rose(s_axi_rvalid)
    && $past(s_axi_araddr[11:2]) == 10'h002)) else $error("pop pulse not tied to data read");
  a_push_at_commit: assert property (txPush |-> $rose(s_axi_bvalid))
    else $error("push pulse outside write commit");
  a_tick_single: assert property (portClockTick |=> !portClockTick)
    else $error("prescale tick longer than one cycle");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_irq_reset: assert property ($fell(rst) |-> !intrReq [*3])
    else $error("interrupt raised with cleared mask");
  a_ready_reset: assert property ($fell(rst) |-> ##1 s_axi_awready && s_axi_arready)
    else $error("bus not ready after reset");
endmodule // ssp_status_irq_checker

bind ssp_status_irq ssp_status_irq_checker u_chk (.clk_sys, .rst, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .rxPop, .txPush, .portClockTick, .intrReq);

// *** dv/ssp_fifo_model.sv ***
// Behavioural model of the FIFOs beside the status block
`timescale 1ns/100ps
module ssp_fifo_model
  import ssp_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   ldEn,
  input  wire logic [SSP_LEVEL_W-1:0] ldTx,
  input  wire logic [SSP_LEVEL_W-1:0] ldRx,
  input  wire logic                   rxPop,
  input  wire logic                   txPush,
  output logic      [SSP_LEVEL_W-1:0] txLevel,
  output logic      [SSP_LEVEL_W-1:0] rxLevel,
  output logic      [SSP_SER_W-1:0]   rxData
);
  // Head word follows the level, so a stale entry cannot pass as fresh
  assign rxData = {12'hc30, rxLevel};
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txLevel <= SSP_LEVEL_EMPTY;
      rxLevel <= SSP_LEVEL_EMPTY;
    end else if (ldEn) begin
      txLevel <= ldTx;
      rxLevel <= ldRx;
    end else begin
      if (txPush && txLevel != SSP_FIFO_DEPTH) txLevel <= txLevel + 4'h1;
      if (rxPop && rxLevel != SSP_LEVEL_EMPTY) rxLevel <= rxLevel - 4'h1;
    end
  end
endmodule // ssp_fifo_model

// *** dv/testbench.sv ***
// Self-checking bench for the serial port status block
`timescale 1ns/100ps
module testbench;
  import ssp_pkg::*;
  typedef struct packed {logic wr; logic [11:0] a; logic [7:0] d; logic [3:0] tx;
    logic [3:0] rx; logic port_busy_flag; logic [7:0] e; logic [1:0] r;} ssp_row_t;
  logic                  clk_sys = 1'h0, rst = 1'h1, ldEn = 1'h0, frameActive = 1'h0;
  logic [SSP_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [SSP_DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic                  s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic                  s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]            s_axi_bresp, s_axi_rresp, rsp;
  logic                  rxTimeoutEvt = 1'h0, rxOverrunEvt = 1'h0;
  logic [3:0]            txLevel, rxLevel, ldTx = '0, ldRx = '0, s_axi_wstrb = 4'hf;
  logic [15:0]           rxData, txData, lastTx = '0;
  logic                  rxPop, txPush, portClockTick, intrReq;
  int                    errTotal = 0, checksDone = 0, cyc = 0, pushCnt = 0, n = 0;
  ssp_row_t              rows [23] = '{
    '{1'h0,12'h00c,8'h00,4'h0,4'h0,1'h0,8'h03,2'h0}, '{1'h0,12'h00c,8'h00,4'h8,4'h8,1'h1,8'h1c,2'h0},
    '{1'h0,12'h00c,8'h00,4'h3,4'h1,1'h0,8'h16,2'h0}, '{1'h0,12'h00c,8'h00,4'h0,4'h0,1'h1,8'h13,2'h0},
    '{1'h0,12'h018,8'h00,4'h4,4'h4,1'h0,8'h0c,2'h0}, '{1'h0,12'h018,8'h00,4'h5,4'h3,1'h0,8'h00,2'h0},
    '{1'h1,12'h010,8'h33,4'h0,4'h0,1'h0,8'h00,2'h0}, '{1'h0,12'h010,8'h00,4'h0,4'h0,1'h0,8'h32,2'h0},
    '{1'h1,12'h014,8'h0f,4'h0,4'h0,1'h0,8'h00,2'h0}, '{1'h0,12'h014,8'h00,4'h0,4'h0,1'h0,8'h0f,2'h0},
    '{1'h0,12'h01c,8'h00,4'h0,4'h8,1'h0,8'h0c,2'h0}, '{1'h1,12'h018,8'h0f,4'h0,4'h0,1'h0,8'h00,2'h0},
    '{1'h0,12'h018,8'h00,4'h0,4'h0,1'h0,8'h08,2'h0}, '{1'h1,12'h01c,8'h0f,4'h0,4'h0,1'h0,8'h00,2'h0},
    '{1'h0,12'h01c,8'h00,4'h5,4'h0,1'h0,8'h00,2'h0}, '{1'h1,12'h014,8'h05,4'h0,4'h0,1'h0,8'h00,2'h0},
    '{1'h0,12'h014,8'h00,4'h0,4'h0,1'h0,8'h05,2'h0}, '{1'h0,12'hfd0,8'h00,4'h0,4'h0,1'h0,8'h5a,2'h0},
    '{1'h0,12'hfd4,8'h00,4'h0,4'h0,1'h0,8'h3c,2'h0}, '{1'h0,12'hfd8,8'h00,4'h0,4'h0,1'h0,8'h71,2'h0},
    '{1'h0,12'h100,8'h00,4'h0,4'h0,1'h0,8'h00,2'h2}, '{1'h1,12'h100,8'h01,4'h0,4'h0,1'h0,8'h00,2'h2},
    '{1'h0,12'h020,8'h00,4'h0,4'h0,1'h0,8'h00,2'h0}};

  ssp_status_irq u_dut (.clk_sys, .rst, .clkEn(1'h1), .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .txLevel, .rxLevel, .frameActive, .rxData, .rxTimeoutEvt,
    .rxOverrunEvt, .rxPop, .txPush, .txData, .portClockTick, .intrReq);
  ssp_fifo_model u_fifo (.clk_sys, .rst, .ldEn, .ldTx, .ldRx, .rxPop, .txPush, .txLevel,
    .rxLevel, .rxData);

  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (txPush === 1'h1) begin
      pushCnt++;
      lastTx = txData;
    end
    // Whole run needs under a thousand cycles; this leaves ample margin
    if (cyc == 20000) begin
      errTotal++;
      endSim();
    end
  end

  task automatic endSim();
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic axiWr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        break;
      end
    end
  endtask
  task automatic axiRd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        break;
      end
    end
  endtask
  task automatic wrOk(input logic [11:0] a, input logic [31:0] d);
    axiWr(a, d, rsp);
    chk({30'h0, rsp}, {30'h0, SSP_RESP_OKAY}, "write resp");
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
    axiRd(a, rd, rsp);
    chk(rd, e, "read data");
  endtask
  task automatic setLv(input logic [3:0] t, input logic [3:0] x, input logic b);
    @(posedge clk_sys);
    ldTx <= t;
    ldRx <= x;
    frameActive <= b;
    ldEn <= 1'h1;
    @(posedge clk_sys);
    ldEn <= 1'h0;
  endtask
  task automatic evt(input logic tmo);
    @(posedge clk_sys);
    if (tmo) rxTimeoutEvt <= 1'h1;
    else rxOverrunEvt <= 1'h1;
    @(posedge clk_sys);
    rxTimeoutEvt <= 1'h0;
    rxOverrunEvt <= 1'h0;
  endtask
  task automatic waitTick(output int k);
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (portClockTick !== 1'h1 && k < 600);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'h0;
    repeat (2) @(posedge clk_sys);
    foreach (rows[i]) begin
      setLv(rows[i].tx, rows[i].rx, rows[i].port_busy_flag);
      if (rows[i].wr) axiWr(rows[i].a, {24'h0, rows[i].d}, rsp);
      else begin
        axiRd(rows[i].a, rd, rsp);
        chk(rd, {24'h0, rows[i].e}, "row data");
      end
      chk({30'h0, rsp}, {30'h0, rows[i].r}, "table resp");
    end
    $display("register table done");
    setLv(4'h2, 4'h3, 1'h0);
    wrOk(SSP_OFS_DATA, 32'hbeef1234);
    rdChk(SSP_OFS_DATA, 32'h0000c303);
    // Monitor and model settle on the edge after the answer
    @(posedge clk_sys);
    chk({16'h0, lastTx}, 32'h1234, "pushed word");
    chk(32'(pushCnt), 32'h1, "push count");
    chk({28'h0, rxLevel}, 32'h2, "pop taken");
    $display("data port done");
    wrOk(SSP_OFS_MASK, 32'h3);
    setLv(4'h8, 4'h0, 1'h0);
    evt(1'h1);
    rdChk(SSP_OFS_RAW, 32'h2);
    chk({31'h0, intrReq}, 32'h1, "irq on timeout");
    wrOk(SSP_OFS_ICLR, 32'h1);
    rdChk(SSP_OFS_RAW, 32'h2);
    wrOk(SSP_OFS_ICLR, 32'h2);
    rdChk(SSP_OFS_RAW, 32'h0);
    evt(1'h0);
    rdChk(SSP_OFS_MIS, 32'h1);
    wrOk(SSP_OFS_ICLR, 32'h3);
    rdChk(SSP_OFS_RAW, 32'h0);
    chk({31'h0, intrReq}, 32'h0, "irq after clear");
    wrOk(SSP_OFS_MASK, 32'h8);
    setLv(4'h0, 4'h0, 1'h0);
    wrOk(SSP_OFS_ICLR, 32'hf);
    chk({31'h0, intrReq}, 32'h1, "level irq kept");
    setLv(4'h8, 4'h0, 1'h0);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, intrReq}, 32'h0, "level irq gone");
    $display("interrupt tests done");
    for (int p = 2; p <= 254; p += 252) begin
      wrOk(SSP_OFS_PRESC, p);
      waitTick(n);
      waitTick(n);
      chk(32'(n), 32'(p), "tick period");
    end
    $display("prescale done");
    // Lane 0 strobe off: write answered but dropped
    s_axi_wstrb <= 4'h0;
    wrOk(SSP_OFS_MASK, 32'h0);
    s_axi_wstrb <= 4'hf;
    rdChk(SSP_OFS_MASK, 32'h8);
    $display("strobe test done");
    @(posedge clk_sys);
    rst <= 1'h1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rdChk(SSP_OFS_PRESC, 32'h0);
    rdChk(SSP_OFS_MASK, 32'h0);
    rdChk(SSP_OFS_STATUS, 32'h3);
    rdChk(SSP_OFS_RAW, 32'h8);
    $display("reset values done");
    endSim();
  end
endmodule // testbench
